// [fec_flash_erase_controller.sv]
/*
  Flash erase controller with its word storage in flip-flops, control
  registers and timing generator. The processor reaches registers and
  flash over one plain port; read data stand only in the next cycle.
  Assumes the three timing clock sources arrive asynchronously.
*/
// Functional notes
// - Idle means read mode: timing generator off, flash reads like ROM.
// - Flash is programmable per bit, byte or word.
// - Erased bits read 1; programming only clears bits.
// - Smallest erase unit is a segment.
// - Info: four 64-byte segments; main: 512-byte segments.
// - Main and info regions operate alike, differing in size and range.
// - Modes: word write, block write, segment, mass, all erase.
// - Mass and erase selects choose segment, main-only or all erase.
// - Global select extends mass erase to both arrays.
// - All erase skips info memory while segment A protect is set.
// - Protected segment A refuses writes and erases.
// - Writing 1 toggles the protect bit; 0 leaves it.
// - A dummy write inside the erase range starts the erase.
// - Busy rises right after the dummy write, holds all erase.
// - Completion clears busy, global, mass and erase selects.
// - Erase duration independent of flash size.
// - Dummy write outside the range is silently ignored.
// - Timing clock: aux, sub-main or main clock, then divider.
// - Flash access while busy from RAM sets the violation flag.
// - Erase started from flash stalls the processor until done.
`timescale 1ns/1ps
module fec_flash_erase_controller
  import fec_pkg::*;
#(
  parameter int ERASE_TICKS = ERASE_TICKS_DEFAULT
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire fec_bus_req_type bus_req,
  input wire logic aux_clk_pin,
  input wire logic sub_main_clock,
  input wire logic main_clk_pin,
  output logic [15:0] rd_data,
  output logic flash_busy,
  output logic cpu_hold,
  output logic access_violation_flag
);

  localparam logic [15:0] ERASE_LIMIT = 16'(ERASE_TICKS);

  fec_state_type state_ff;
  logic [15:0] mem_ff [MEM_WORDS];
  logic [15:0] rd_data_ff;
  logic busy_ff;
  logic hold_ff;
  logic viol_ff;
  logic erase_sel_ff;
  logic mass_erase_sel_ff;
  logic global_array_erase_sel_ff;
  logic array_sel_ff;
  logic word_program_sel_ff;
  logic block_program_sel_ff;
  logic [5:0] timing_clock_divider_ff;
  fec_src_type src_ff;
  logic lock_ff;
  logic info_seg_a_protect_ff;
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic [2:0] sync3_ff;
  logic [5:0] div_cnt_ff;
  logic [15:0] ticks_ff;
  logic [10:0] er_lo_ff;
  logic [10:0] er_hi_ff;

  logic is_flash;
  logic is_info;
  logic [10:0] idx;
  logic seg_a_hit;
  logic erase_mode;
  logic in_range;
  logic start_erase;
  logic start_prog;
  logic flash_access;
  logic reg_wr;
  logic src_now;
  logic src_old;
  logic ftg_pulse;
  logic op_done;
  logic [10:0] nxt_lo;
  logic [10:0] nxt_hi;
  logic [15:0] prog_mask;

  // Word index of a flash byte address; both regions decode alike
  function automatic logic [10:0] word_index(input logic [15:0] a);
    if (a >= INFO_BASE && a <= INFO_LAST) begin
      word_index = {4'h0, a[7:1]};
    end else if (a >= MAIN_BASE && a <= MAIN_LAST) begin
      word_index = MAIN_IDX_BASE + {1'b0, a[10:1]};
    end else begin
      word_index = 11'h000;
    end
  endfunction

  // Address decode of the current request
  assign is_info = bus_req.addr >= INFO_BASE && bus_req.addr <= INFO_LAST;
  assign is_flash = is_info ||
    (bus_req.addr >= MAIN_BASE && bus_req.addr <= MAIN_LAST);
  assign idx = word_index(bus_req.addr);
  assign seg_a_hit = is_info && idx <= INFO_SEG_SPAN;
  assign flash_access = is_flash && (bus_req.wr || bus_req.rd);
  assign reg_wr = bus_req.wr && !busy_ff;
  assign erase_mode = erase_sel_ff || mass_erase_sel_ff;

  // Erase range from the mode bits, as word index bounds
  always_comb begin
    nxt_lo = MAIN_IDX_BASE;
    nxt_hi = ARR0_IDX_LAST;
    if (!mass_erase_sel_ff) begin
      if (is_info) begin
        nxt_lo = {idx[10:5], 5'h00};
        nxt_hi = nxt_lo + INFO_SEG_SPAN;
      end else begin
        nxt_lo = MAIN_IDX_BASE + {1'b0, bus_req.addr[10:9], 8'h00};
        nxt_hi = nxt_lo + MAIN_SEG_SPAN;
      end
    end else if (global_array_erase_sel_ff) begin
      nxt_lo = MAIN_IDX_BASE;
      nxt_hi = ARR1_IDX_LAST;
    end else if (array_sel_ff) begin
      nxt_lo = ARR1_IDX_BASE;
      nxt_hi = ARR1_IDX_LAST;
    end
    if (mass_erase_sel_ff && erase_sel_ff && !info_seg_a_protect_ff &&
        (global_array_erase_sel_ff || !array_sel_ff)) begin
      nxt_lo = 11'h000;
    end
  end

  // range check for the dummy write
  assign in_range = is_flash && idx >= nxt_lo && idx <= nxt_hi &&
    !(seg_a_hit && info_seg_a_protect_ff);
  // accepted only unlocked, idle, with an erase mode
  assign start_erase = bus_req.wr && state_ff == FEC_IDLE && !lock_ff &&
    erase_mode && in_range;
  // word or block write, segment A refusal
  assign start_prog = bus_req.wr && state_ff == FEC_IDLE && !lock_ff &&
    !erase_mode && (word_program_sel_ff || block_program_sel_ff) &&
    is_flash && !(seg_a_hit && info_seg_a_protect_ff);
  assign prog_mask = {{8{bus_req.byte_en[1]}}, {8{bus_req.byte_en[0]}}};

  // Two-stage synchronisers on the clock source pins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      sync3_ff <= 3'h0;
    end else begin
      sync1_ff <= {main_clk_pin, sub_main_clock, aux_clk_pin};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  always_comb begin
    case (src_ff)
      FEC_SRC_AUX: begin
        src_now = sync2_ff[0];
        src_old = sync3_ff[0];
      end
      FEC_SRC_SUB: begin
        src_now = sync2_ff[1];
        src_old = sync3_ff[1];
      end
      default: begin
        src_now = sync2_ff[2];
        src_old = sync3_ff[2];
      end
    endcase
  end

  // Divider output; counts only while an operation runs
  assign ftg_pulse = busy_ff && src_now && !src_old &&
    div_cnt_ff == timing_clock_divider_ff;
  // fixed tick count, whatever the array size
  assign op_done = ftg_pulse &&
    ((state_ff == FEC_ERASE && ticks_ff == ERASE_LIMIT - 16'h0001) ||
     (state_ff == FEC_PROG && ticks_ff == PROG_TICKS - 16'h0001));

  // divider held at zero while idle
  // Cleared on the completion pulse too, so idle never shows a stale count
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt_ff <= 6'h00;
      ticks_ff <= 16'h0000;
    end else if (!busy_ff || op_done) begin
      div_cnt_ff <= 6'h00;
      ticks_ff <= 16'h0000;
    end else if (src_now && !src_old) begin
      div_cnt_ff <= ftg_pulse ? 6'h00 : div_cnt_ff + 6'h01;
      ticks_ff <= ftg_pulse ? ticks_ff + 16'h0001 : ticks_ff;
    end
  end

  // Operation sequencer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= FEC_IDLE;
      busy_ff <= 1'b0;
      er_lo_ff <= 11'h000;
      er_hi_ff <= 11'h000;
    end else begin
      case (state_ff)
        FEC_IDLE: begin
          // dummy write starts erase, busy next cycle
          if (start_erase) begin
            state_ff <= FEC_ERASE;
            busy_ff <= 1'b1;
            er_lo_ff <= nxt_lo;
            er_hi_ff <= nxt_hi;
          end else if (start_prog) begin
            state_ff <= FEC_PROG;
            busy_ff <= 1'b1;
          end
        end
        default: begin
          if (op_done) begin
            state_ff <= FEC_IDLE;
            busy_ff <= 1'b0;
          end
        end
      endcase
    end
  end

  // stall only when the starting write, dummy or program, came from flash code
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_ff <= 1'b0;
    end else if (start_erase || start_prog) begin
      hold_ff <= bus_req.from_flash;
    end else if (op_done) begin
      hold_ff <= 1'b0;
    end
  end

  // Storage; reset leaves everything erased
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < MEM_WORDS; i++) begin
        mem_ff[i] <= ERASED_WORD;
      end
    end else if (start_prog) begin
      // byte lanes, bits only go 1 to 0
      mem_ff[idx] <= mem_ff[idx] & (bus_req.wdata | ~prog_mask);
    end else if (op_done && state_ff == FEC_ERASE) begin
      // erase sets every word of the range to ones
      for (int i = 0; i < MEM_WORDS; i++) begin
        if (11'(i) >= er_lo_ff && 11'(i) <= er_hi_ff) begin
          mem_ff[i] <= ERASED_WORD;
        end
      end
    end
  end

  // Mode select bits; frozen while busy
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      erase_sel_ff <= 1'b0;
      mass_erase_sel_ff <= 1'b0;
      global_array_erase_sel_ff <= 1'b0;
      array_sel_ff <= 1'b0;
      word_program_sel_ff <= 1'b0;
      block_program_sel_ff <= 1'b0;
    end else if (op_done && state_ff == FEC_ERASE) begin
      erase_sel_ff <= 1'b0;
      mass_erase_sel_ff <= 1'b0;
      global_array_erase_sel_ff <= 1'b0;
    end else if (reg_wr && bus_req.addr == CTRL1_ADDR) begin
      erase_sel_ff <= bus_req.wdata[ERASE_BIT];
      mass_erase_sel_ff <= bus_req.wdata[MASS_BIT];
      global_array_erase_sel_ff <= bus_req.wdata[GLOBAL_BIT];
      array_sel_ff <= bus_req.wdata[ARRAY_BIT];
      word_program_sel_ff <= bus_req.wdata[WORD_PROG_BIT];
      block_program_sel_ff <= bus_req.wdata[BLOCK_PROG_BIT];
    end
  end

  // Clock source and divider setting
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timing_clock_divider_ff <= DIV_RESET;
      src_ff <= fec_src_type'(SRC_RESET);
    end else if (reg_wr && bus_req.addr == CTRL2_ADDR) begin
      timing_clock_divider_ff <= bus_req.wdata[DIV_LSB +: 6];
      src_ff <= fec_src_type'(bus_req.wdata[SRC_LSB +: 2]);
    end
  end

  // Lock and protect bits
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_ff <= LOCK_RESET;
      info_seg_a_protect_ff <= PROT_RESET;
    end else if (reg_wr && bus_req.addr == CTRL3_ADDR) begin
      lock_ff <= bus_req.wdata[LOCK_BIT];
      // a one toggles, a zero keeps
      if (bus_req.wdata[PROT_BIT]) begin
        info_seg_a_protect_ff <= !info_seg_a_protect_ff;
      end
    end
  end

  // Violation flag; a new violation beats a same-cycle clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      viol_ff <= 1'b0;
    end else if (busy_ff && !hold_ff && flash_access) begin
      // flash touched during a RAM-started operation
      viol_ff <= 1'b1;
    end else if (bus_req.wr && bus_req.addr == CTRL3_ADDR &&
                 !bus_req.wdata[VIOL_BIT]) begin
      viol_ff <= 1'b0;
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_ff <= 16'h0000;
    end else if (!bus_req.rd) begin
      rd_data_ff <= 16'h0000;
    end else if (bus_req.addr == CTRL1_ADDR) begin
      rd_data_ff <= 16'h0000;
      rd_data_ff[ERASE_BIT] <= erase_sel_ff;
      rd_data_ff[MASS_BIT] <= mass_erase_sel_ff;
      rd_data_ff[GLOBAL_BIT] <= global_array_erase_sel_ff;
      rd_data_ff[ARRAY_BIT] <= array_sel_ff;
      rd_data_ff[WORD_PROG_BIT] <= word_program_sel_ff;
      rd_data_ff[BLOCK_PROG_BIT] <= block_program_sel_ff;
    end else if (bus_req.addr == CTRL2_ADDR) begin
      rd_data_ff <= {8'h00, src_ff, timing_clock_divider_ff};
    end else if (bus_req.addr == CTRL3_ADDR) begin
      rd_data_ff <= 16'h0000;
      rd_data_ff[BUSY_BIT] <= busy_ff;
      rd_data_ff[VIOL_BIT] <= viol_ff;
      rd_data_ff[LOCK_BIT] <= lock_ff;
      rd_data_ff[PROT_BIT] <= info_seg_a_protect_ff;
    end else if (is_flash && busy_ff) begin
      // Array is unreadable mid-operation
      rd_data_ff <= BUSY_READ_WORD;
    end else if (is_flash) begin
      rd_data_ff <= mem_ff[idx];
    end else begin
      rd_data_ff <= 16'h0000;
    end
  end

  assign rd_data = rd_data_ff;
  assign flash_busy = busy_ff;
  assign cpu_hold = hold_ff;
  assign access_violation_flag = viol_ff;

  // Helpers for the checks below
  logic [10:0] chk_idx_ff;
  logic [15:0] chk_old_ff;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chk_idx_ff <= 11'h000;
      chk_old_ff <= 16'h0000;
    end else begin
      chk_idx_ff <= idx;
      chk_old_ff <= mem_ff[idx];
    end
  end

  sequence seq_flash_start;
    start_erase && bus_req.from_flash;
  endsequence

  sequence seq_erase_end;
    op_done && state_ff == FEC_ERASE;
  endsequence

  AST_BUSY_RISE: assert property (
    @(posedge clk) disable iff (sys_rst)
    start_erase |=> flash_busy && state_ff == FEC_ERASE)
    else $error("busy did not rise after dummy write");

  AST_BUSY_STAYS: assert property (
    @(posedge clk) disable iff (sys_rst)
    busy_ff && !op_done |=> busy_ff)
    else $error("busy fell before completion");

  AST_AUTO_CLEAR: assert property (
    @(posedge clk) disable iff (sys_rst)
    seq_erase_end |=> !busy_ff && !erase_sel_ff && !mass_erase_sel_ff &&
      !global_array_erase_sel_ff)
    else $error("selects not cleared at erase end");

  AST_IDLE_QUIET: assert property (
    @(posedge clk) disable iff (sys_rst)
    state_ff == FEC_IDLE |-> !ftg_pulse && ticks_ff == 16'h0000)
    else $error("timing generator running while idle");

  AST_ONE_WAY: assert property (
    @(posedge clk) disable iff (sys_rst)
    start_prog |=> (mem_ff[chk_idx_ff] & ~chk_old_ff) == 16'h0000)
    else $error("programming set a bit to one");

  AST_PROTECT_TOGGLE: assert property (
    @(posedge clk) disable iff (sys_rst)
    reg_wr && bus_req.addr == CTRL3_ADDR |=>
      info_seg_a_protect_ff ==
      ($past(info_seg_a_protect_ff) ^ $past(bus_req.wdata[PROT_BIT])))
    else $error("protect bit did not follow toggle write");

  AST_IGNORED_WRITE: assert property (
    @(posedge clk) disable iff (sys_rst)
    bus_req.wr && state_ff == FEC_IDLE && erase_mode && !in_range |=>
      !busy_ff && !$rose(viol_ff))
    else $error("stray dummy write had an effect");

  AST_SEG_A_SAFE: assert property (
    @(posedge clk) disable iff (sys_rst)
    info_seg_a_protect_ff && seg_a_hit && bus_req.wr |->
      !start_erase && !start_prog)
    else $error("protected segment accepted an update");

  AST_VIOLATION: assert property (
    @(posedge clk) disable iff (sys_rst)
    busy_ff && !hold_ff && flash_access |=> access_violation_flag)
    else $error("violation flag not set");

  AST_STALL: assert property (
    @(posedge clk) disable iff (sys_rst)
    seq_flash_start |=> cpu_hold throughout (busy_ff [*8]))
    else $error("processor not held during flash-started erase");

endmodule

// [fec_pkg.sv]
/*
  Shared constants and carrier types for the flash erase controller:
  the memory map, control register layout, reset values and timing.
  Assumes a single 125 MHz system clock and a 16-bit byte address bus.
*/
package fec_pkg;

  // Memory map, byte addresses
  localparam logic [15:0] CTRL1_ADDR = 16'h0000;
  localparam logic [15:0] CTRL2_ADDR = 16'h0002;
  localparam logic [15:0] CTRL3_ADDR = 16'h0004;
  localparam logic [15:0] INFO_BASE = 16'h1000;
  localparam logic [15:0] INFO_LAST = 16'h10FF;
  localparam logic [15:0] MAIN_BASE = 16'h8000;
  localparam logic [15:0] MAIN_LAST = 16'h87FF;

  // Word storage: info 0..127, array 0 128..639, array 1 640..1151
  localparam int MEM_WORDS = 1152;
  localparam logic [10:0] INFO_IDX_LAST = 11'h07F;
  localparam logic [10:0] MAIN_IDX_BASE = 11'h080;
  localparam logic [10:0] ARR0_IDX_LAST = 11'h27F;
  localparam logic [10:0] ARR1_IDX_BASE = 11'h280;
  localparam logic [10:0] ARR1_IDX_LAST = 11'h47F;
  localparam logic [10:0] INFO_SEG_SPAN = 11'h01F;
  localparam logic [10:0] MAIN_SEG_SPAN = 11'h0FF;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [15:0] BUSY_READ_WORD = 16'h3FFF;

  // CTRL1 field positions
  localparam int ERASE_BIT = 1;
  localparam int MASS_BIT = 2;
  localparam int GLOBAL_BIT = 3;
  localparam int ARRAY_BIT = 4;
  localparam int WORD_PROG_BIT = 6;
  localparam int BLOCK_PROG_BIT = 7;
  // CTRL2 field positions
  localparam int DIV_LSB = 0;
  localparam int SRC_LSB = 6;
  // CTRL3 field positions
  localparam int BUSY_BIT = 0;
  localparam int VIOL_BIT = 2;
  localparam int LOCK_BIT = 4;
  localparam int PROT_BIT = 6;

  // Reset values
  localparam logic [5:0] DIV_RESET = 6'h00;
  localparam logic [1:0] SRC_RESET = 2'h0;
  localparam logic LOCK_RESET = 1'b1;
  localparam logic PROT_RESET = 1'b1;

  // Timing generator periods per operation
  localparam logic [15:0] PROG_TICKS = 16'h0023;
  localparam int ERASE_TICKS_DEFAULT = 5000;

  typedef enum logic [1:0] {
    FEC_SRC_AUX,
    FEC_SRC_SUB,
    FEC_SRC_MAIN,
    FEC_SRC_MAIN2
  } fec_src_type;

  typedef enum logic [1:0] {
    FEC_IDLE,
    FEC_ERASE,
    FEC_PROG
  } fec_state_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [1:0] byte_en;
    logic wr;
    logic rd;
    logic from_flash;
  } fec_bus_req_type;

endpackage

// [fec_cpu_model.sv]
/*
  Processor model on the controller's plain memory port.
  Assumes one rising-edge clock; reads return one cycle after strobe.
*/
`timescale 1ns/1ps
module fec_cpu_model
  import fec_pkg::*;
(
  input wire logic clk,
  input wire logic [15:0] rd_data,
  output fec_bus_req_type bus_req
);
  initial begin
    bus_req = '0;
  end

  // no flash access while busy unless a test asks
  task automatic wr(input logic [15:0] a, input logic [15:0] d,
                    input logic [1:0] be, input logic ff);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.byte_en <= be;
    bus_req.from_flash <= ff;
    bus_req.wr <= 1'b1;
    @(posedge clk);
    bus_req.wr <= 1'b0;
    // Released lines show junk, not the last value
    bus_req.addr <= ~a;
    bus_req.wdata <= ~d;
  endtask

  // Data sampled in the cycle after the strobe only
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    bus_req.addr <= ~a;
    #1;
    d = rd_data;
  endtask
endmodule

// [fec_flash_erase_controller_tb_top.sv]
/*
  Self-checking bench for the flash erase controller.
  Assumes the cpu model drives the port; sources are slow square waves.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin \
  checks++; \
  if ((a) !== (b)) begin \
    fails++; \
    $display("wrong value t=%0t got %h exp %h", $time, (a), (b)); \
  end \
end
module fec_flash_erase_controller_tb_top;
  import fec_pkg::*;
  // Short erase keeps the run small
  localparam int TICKS = 6;
  logic clk;
  logic sys_rst;
  logic aux_clk_pin;
  logic sub_main_clock;
  logic main_clk_pin;
  fec_bus_req_type bus_req;
  logic [15:0] rd_data;
  logic flash_busy;
  logic cpu_hold;
  logic access_violation_flag;
  int fails;
  int checks;
  int cycles;
  int div;
  logic [15:0] v;

  fec_cpu_model cpu (.clk(clk), .rd_data(rd_data), .bus_req(bus_req));

  fec_flash_erase_controller #(.ERASE_TICKS(TICKS)) uut (
    .clk(clk),
    .sys_rst(sys_rst),
    .bus_req(bus_req),
    .aux_clk_pin(aux_clk_pin),
    .sub_main_clock(sub_main_clock),
    .main_clk_pin(main_clk_pin),
    .rd_data(rd_data),
    .flash_busy(flash_busy),
    .cpu_hold(cpu_hold),
    .access_violation_flag(access_violation_flag)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // sources slow enough to sync, distinct rates
  initial begin
    aux_clk_pin = 1'b0;
    sub_main_clock = 1'b0;
    main_clk_pin = 1'b0;
    div = 0;
  end
  always @(posedge clk) begin
    div <= div + 1;
    if (div % 4 == 0) aux_clk_pin <= ~aux_clk_pin;
    if (div % 3 == 0) sub_main_clock <= ~sub_main_clock;
    if (div % 5 == 0) main_clk_pin <= ~main_clk_pin;
  end

  // Hang guard, well above the expected run
  initial cycles = 0;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [15:0] m,
                     input logic [15:0] e);
    cpu.rd(a, v);
    `CHK(v & m, e)
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    @(negedge clk);
    while (flash_busy !== 1'b0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000) fails++;
  endtask

  task automatic prog(input logic [15:0] a, input logic [15:0] d,
                      input logic [1:0] be);
    cpu.wr(a, d, be, 1'b0);
    wait_idle();
  endtask

  // Mode, dummy write, optional access while busy
  task automatic erase(input logic [15:0] c, input logic [15:0] a,
                       input logic ff, input logic poke);
    cpu.wr(CTRL1_ADDR, c, 2'b11, 1'b0);
    cpu.wr(a, 16'h0000, 2'b11, ff);
    #1;
    `CHK(flash_busy, 1'b1)
    `CHK(cpu_hold, ff)
    if (poke) begin
      rdc(MAIN_BASE, 16'hFFFF, BUSY_READ_WORD);
      `CHK(access_violation_flag, 1'b1)
    end
    wait_idle();
    `CHK(cpu_hold, 1'b0)
    rdc(CTRL1_ADDR, 16'h000E, 16'h0000);
  endtask

  initial begin
    fails = 0;
    checks = 0;
    sys_rst = 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset state: locked, protected, idle, erased
    rdc(CTRL3_ADDR, 16'h0055, 16'h0050);
    rdc(CTRL1_ADDR, 16'h00DE, 16'h0000);
    rdc(MAIN_BASE, 16'hFFFF, ERASED_WORD);
    rdc(16'h4000, 16'hFFFF, 16'h0000);
    // Locked flash ignores a program request
    cpu.wr(CTRL1_ADDR, 16'h0040, 2'b11, 1'b0);
    cpu.wr(MAIN_BASE, 16'h1234, 2'b11, 1'b0);
    #1;
    `CHK(flash_busy, 1'b0)
    cpu.wr(CTRL3_ADDR, 16'h0000, 2'b11, 1'b0);
    rdc(CTRL3_ADDR, 16'h0050, 16'h0040);
    // Programming only clears bits, per lane
    prog(MAIN_BASE, 16'h1234, 2'b11);
    prog(MAIN_BASE, 16'hFF0F, 2'b11);
    rdc(MAIN_BASE, 16'hFFFF, 16'h1204);
    prog(16'h8002, 16'h0000, 2'b01);
    rdc(16'h8002, 16'hFFFF, 16'hFF00);
    prog(16'h8200, 16'h5555, 2'b11);
    prog(16'h1040, 16'hAAAA, 2'b11);
    prog(16'h8400, 16'h0000, 2'b11);
    cpu.wr(INFO_BASE, 16'h0000, 2'b11, 1'b0);
    #1;
    `CHK(flash_busy, 1'b0)
    rdc(INFO_BASE, 16'hFFFF, ERASED_WORD);
    // Segment erase from RAM
    erase(16'h0002, 16'h8004, 1'b0, 1'b0);
    rdc(MAIN_BASE, 16'hFFFF, ERASED_WORD);
    rdc(16'h8002, 16'hFFFF, ERASED_WORD);
    rdc(16'h8200, 16'hFFFF, 16'h5555);
    // Dummy write outside any flash range
    cpu.wr(CTRL1_ADDR, 16'h0002, 2'b11, 1'b0);
    cpu.wr(16'h4000, 16'h0000, 2'b11, 1'b0);
    #1;
    `CHK(flash_busy, 1'b0)
    `CHK(access_violation_flag, 1'b0)
    // Sub-main source, divide by two
    cpu.wr(CTRL2_ADDR, 16'h0041, 2'b11, 1'b0);
    rdc(CTRL2_ADDR, 16'h00FF, 16'h0041);
    // All erase from flash, protect set keeps info
    erase(16'h0006, 16'h8000, 1'b1, 1'b0);
    rdc(16'h8200, 16'hFFFF, ERASED_WORD);
    rdc(16'h1040, 16'hFFFF, 16'hAAAA);
    rdc(16'h8400, 16'hFFFF, 16'h0000);
    // Writing one toggles protect, zero keeps it
    cpu.wr(CTRL3_ADDR, 16'h0040, 2'b11, 1'b0);
    cpu.wr(CTRL3_ADDR, 16'h0000, 2'b11, 1'b0);
    rdc(CTRL3_ADDR, 16'h0050, 16'h0000);
    // Global all erase reaches both arrays and info
    erase(16'h000E, 16'h8400, 1'b0, 1'b0);
    rdc(16'h8400, 16'hFFFF, ERASED_WORD);
    rdc(16'h1040, 16'hFFFF, ERASED_WORD);
    // Block mode programs; unprotected segment A takes writes
    cpu.wr(CTRL1_ADDR, 16'h0080, 2'b11, 1'b0);
    prog(INFO_BASE, 16'h1234, 2'b11);
    prog(MAIN_BASE, 16'h00FF, 2'b11);
    prog(16'h8400, 16'h0F0F, 2'b11);
    rdc(INFO_BASE, 16'hFFFF, 16'h1234);
    rdc(16'h8400, 16'hFFFF, 16'h0F0F);
    // Second array selected: the first array is out of range
    cpu.wr(CTRL1_ADDR, 16'h0014, 2'b11, 1'b0);
    cpu.wr(MAIN_BASE, 16'h0000, 2'b11, 1'b0);
    #1;
    `CHK(flash_busy, 1'b0)
    erase(16'h0014, 16'h8400, 1'b0, 1'b0);
    rdc(16'h8400, 16'hFFFF, ERASED_WORD);
    rdc(MAIN_BASE, 16'hFFFF, 16'h00FF);
    // All erase with protect clear takes info too
    erase(16'h0006, INFO_BASE, 1'b0, 1'b0);
    rdc(INFO_BASE, 16'hFFFF, ERASED_WORD);
    rdc(MAIN_BASE, 16'hFFFF, ERASED_WORD);
    // Main source; mass erase with a forbidden read
    cpu.wr(CTRL2_ADDR, 16'h0080, 2'b11, 1'b0);
    erase(16'h0004, 16'h8000, 1'b0, 1'b1);
    cpu.wr(CTRL3_ADDR, 16'h0000, 2'b11, 1'b0);
    #1;
    `CHK(access_violation_flag, 1'b0)
    results();
  end
endmodule
